/* hdl/modem_pkg.sv */
/*
  Constants, field positions and types of the modem host serial port.
  Assumes a 200 MHz system clock and a 48-bit control register.
*/
// Contract
// - Select and direction levels decode to transmit, receive, register read, register write.
// - Select and direction act on present levels; only select falling edge matters.
// - Interface select low picks SPI style, high picks UART style.
// - Idle receive line sits at the interface select level.
// - UART transmits asynchronously only; SPI uses synchronous access both ways.
// - Asynchronous receive passes idle, delivers data after the settle time.
// - Transmit goes idle, powers transmitter, sends after the settle time.
// - In synchronous mode the device alone drives the bit clock.
// - Synchronous receive recovers the bit clock; data stable at rising edges.
// - Synchronous transmit samples the transmit line on rising bit clock edges.
// - Synchronous receive holds bit clock low while idle, data after settle.
// - Register access is always synchronous with device supplied clock.
// - Register write bits arrive MSB first, sampled on rising bit clock edges.
// - Shifted write bits commit only when register select falls.
// - Normal mode keeps only the last 24 bits shifted in.
// - Normal mode short write is dropped; 16 or more bits raise status.
// - Extended mode accepts exactly 24 or 48 bits; else abort, with status at 16 or more bits.
// - Extended 24-bit write touches only bits 23 down to 0.
// - Register read shifts out MSB first, stable at rising edges, 24 bits.
// - Extended read sends 24 bits, or 48 when bit 18 is set.
// - Control bit 14 selects synchronous access for the receive data flow only.
package modem_pkg;
  // ----------------------------------------
  // Register layout
  // ----------------------------------------
  localparam int CREG_W = 48;
  localparam int SHORT_W = 24;
  localparam int MIN_STAT = 16;
  localparam int BIT_EXT = 21;
  localparam int BIT_LONG_RD = 18;
  localparam int BIT_SYNC = 14;
  localparam logic [47:0] CREG_RESET = 48'h0000_0000_0000;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_NS = 5;
  localparam int TCC_NS = 1000;
  localparam int SETTLE_CYC = (TCC_NS + CLK_NS - 1) / CLK_NS;
  localparam int BAUD = 2400;
  localparam int BIT_CYC = 1000000000 / (BAUD * CLK_NS);
  // ----------------------------------------
  // Modes
  // ----------------------------------------
  typedef enum logic [1:0] {md_tx, md_rx, md_rd, md_wr} mode_t;
endpackage

/* hdl/creg_if.sv */
/*
  Carrier between the port logic and the control register store.
  Assumes both ends sit on the same clock.
*/
`timescale 1ns/10ps
`default_nettype none
interface creg_if;
  logic wr_en;
  logic wr_full;
  logic [47:0] wr_data;
  logic [47:0] rd_data;
  modport store (input wr_en, input wr_full, input wr_data, output rd_data);
  modport user (output wr_en, output wr_full, output wr_data, input rd_data);
endinterface
`default_nettype wire

/* hdl/creg_store.sv */
/*
  Control register store: 48 bits, full or low-half write, registered read.
  Assumes write strobes come from logic on the same clock.
*/
`timescale 1ns/10ps
`default_nettype none
module creg_store (
  input wire logic clk,
  input wire logic sys_rst,
  creg_if.store bus
);
  // ----------------------------------------
  // Storage
  // ----------------------------------------
  // A short write leaves the extended half alone
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      bus.rd_data <= modem_pkg::CREG_RESET;
    else if (bus.wr_en && bus.wr_full)
      bus.rd_data <= bus.wr_data;
    else if (bus.wr_en)
      bus.rd_data[23:0] <= bus.wr_data[23:0];
  end
endmodule
`default_nettype wire

/* hdl/modem_host_serial_port.sv */
/*
  Host serial port of a power-line FSK modem: mode decode, settle timing,
  bit clock generation, data paths and control register read and write.
  Assumes demodulator signals come from logic on clk; pins are asynchronous.
*/
`timescale 1ns/10ps
`default_nettype none
module modem_host_serial_port #(
  parameter int SETTLE_CYC = modem_pkg::SETTLE_CYC,
  parameter int BIT_CYC = modem_pkg::BIT_CYC
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic reg_select,
  input wire logic direction_line,
  input wire logic if_select,
  input wire logic txd,
  input wire logic demod_bit,
  input wire logic demod_valid,
  output logic rxd,
  output logic bit_clock_line,
  output logic register_status_output,
  output logic tx_power,
  output logic mod_bit,
  output logic mod_active,
  output logic [47:0] ctrl_word
);
  localparam int HALF = BIT_CYC / 2;
  typedef enum logic {st_idle, st_run} state_t;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [3:0] pin_raw;
  logic [3:0] syn1_ff;
  logic [3:0] syn2_ff;
  assign pin_raw = {txd, if_select, direction_line, reg_select};

  // Two stages per pin; only the second stage is read by logic
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_sync
      always_ff @(posedge clk or posedge sys_rst)
      begin
        if (sys_rst)
        begin
          syn1_ff[gi] <= 1'b0;
          syn2_ff[gi] <= 1'b0;
        end
        else
        begin
          syn1_ff[gi] <= pin_raw[gi];
          syn2_ff[gi] <= syn1_ff[gi];
        end
      end
    end
  endgenerate

  wire rs_s = syn2_ff[0];
  wire dir_s = syn2_ff[1];
  wire is_s = syn2_ff[2];
  wire txd_s = syn2_ff[3];

  // ----------------------------------------
  // Mode decode
  // ----------------------------------------
  function automatic modem_pkg::mode_t decode(input logic rs, input logic dir);
    if (!rs && !dir)
      decode = modem_pkg::md_tx;
    else if (!rs)
      decode = modem_pkg::md_rx;
    else if (dir)
      decode = modem_pkg::md_rd;
    else
      decode = modem_pkg::md_wr;
  endfunction

  modem_pkg::mode_t mode_ff;
  state_t state_ff;
  logic rs_d_ff;
  logic [31:0] settle_ff;
  logic [31:0] bit_cnt_ff;
  logic [47:0] sh_ff;
  logic [5:0] wr_cnt_ff;
  logic [5:0] rd_left_ff;
  logic demod_d_ff;
  creg_if cif ();

  // Levels decode directly; no edge is needed to enter a mode
  modem_pkg::mode_t cur_mode;
  assign cur_mode = decode(rs_s, dir_s);
  wire mode_chg = cur_mode != mode_ff;
  wire rs_fall = rs_d_ff && !rs_s;
  wire is_reg = mode_ff == modem_pkg::md_rd || mode_ff == modem_pkg::md_wr;
  wire is_data = !is_reg;
  wire [47:0] creg = cif.rd_data;
  wire ext = creg[modem_pkg::BIT_EXT];
  wire long_rd = ext && creg[modem_pkg::BIT_LONG_RD];

  // SPI forces synchronous, UART transmit forces asynchronous
  wire sync_tx = !is_s;
  wire sync_rx = !is_s || creg[modem_pkg::BIT_SYNC];
  wire sync_cur = mode_ff == modem_pkg::md_tx ? sync_tx : sync_rx;

  // ----------------------------------------
  // Mode tracking and settle timer
  // ----------------------------------------
  // Data modes idle for the settle time; register modes start at once
  wire settle_done = settle_ff == 32'(SETTLE_CYC - 1);
  wire cur_data = cur_mode == modem_pkg::md_tx || cur_mode == modem_pkg::md_rx;
  state_t nxt_state;

  // Plain branches keep every value assigned to the state of its own type
  always_comb
  begin
    if (mode_chg && cur_data)
      nxt_state = st_idle;
    else if (mode_chg)
      nxt_state = st_run;
    else if (state_ff == st_idle && settle_done)
      nxt_state = st_run;
    else
      nxt_state = state_ff;
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      mode_ff <= modem_pkg::md_tx;
      state_ff <= st_idle;
      settle_ff <= 32'h0000_0000;
      rs_d_ff <= 1'b0;
      demod_d_ff <= 1'b0;
    end
    else
    begin
      mode_ff <= cur_mode;
      state_ff <= nxt_state;
      settle_ff <= (mode_chg || state_ff != st_idle) ? 32'h0000_0000 : settle_ff + 32'h0000_0001;
      rs_d_ff <= rs_s;
      demod_d_ff <= demod_bit;
    end
  end

  // ----------------------------------------
  // Bit clock
  // ----------------------------------------
  // Device is always the clock master; no clock runs in async data modes
  wire rx_lost = mode_ff == modem_pkg::md_rx && !demod_valid;
  wire clk_run = state_ff == st_run && !mode_chg && (is_reg || sync_cur) &&
                 !rx_lost;
  // Crude recovery: realign the bit phase to every demodulated transition
  wire pll_align = mode_ff == modem_pkg::md_rx && demod_bit != demod_d_ff;
  wire tick_rise = clk_run && bit_cnt_ff == 32'(HALF - 1);
  wire tick_fall = clk_run && bit_cnt_ff == 32'(BIT_CYC - 1);
  wire nxt_bclk = clk_run && !pll_align && bit_cnt_ff >= 32'(HALF - 1) &&
                  !tick_fall;
  logic [31:0] nxt_bit_cnt;
  assign nxt_bit_cnt = (!clk_run || pll_align || tick_fall) ? 32'h0000_0000 :
                       bit_cnt_ff + 32'h0000_0001;

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      bit_cnt_ff <= 32'h0000_0000;
      bit_clock_line <= 1'b0;
    end
    else
    begin
      bit_cnt_ff <= nxt_bit_cnt;
      bit_clock_line <= nxt_bclk;
    end
  end

  // ----------------------------------------
  // Transmit path
  // ----------------------------------------
  wire tx_run = mode_ff == modem_pkg::md_tx && state_ff == st_run && !mode_chg;
  // Async passes the pin straight on; sync samples at the rising edge
  wire nxt_mod = !tx_run ? mod_bit : sync_tx ? (tick_rise ? txd_s : mod_bit) :
                 txd_s;

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      tx_power <= 1'b0;
      mod_bit <= 1'b0;
      mod_active <= 1'b0;
    end
    else
    begin
      tx_power <= cur_mode == modem_pkg::md_tx;
      mod_bit <= nxt_mod;
      mod_active <= tx_run;
    end
  end

  // ----------------------------------------
  // Register shift engine
  // ----------------------------------------
  wire enter_rd = mode_chg && cur_mode == modem_pkg::md_rd;
  wire enter_wr = mode_chg && cur_mode == modem_pkg::md_wr;
  wire in_wr = mode_ff == modem_pkg::md_wr && !mode_chg;
  wire in_rd = mode_ff == modem_pkg::md_rd && !mode_chg;
  wire wr_shift = in_wr && tick_rise;
  wire rd_shift = in_rd && tick_fall && rd_left_ff != 6'h00;
  // Short reads park the low half at the top so bit 47 is always sent
  wire [47:0] rd_load = long_rd ? creg : {creg[23:0], 24'h00_0000};
  wire [5:0] rd_len = long_rd ? 6'(modem_pkg::CREG_W) : 6'(modem_pkg::SHORT_W);
  wire [47:0] nxt_sh = enter_rd ? rd_load :
                       enter_wr ? 48'h0000_0000_0000 :
                       wr_shift ? {sh_ff[46:0], txd_s} :
                       rd_shift ? {sh_ff[46:0], 1'b0} : sh_ff;

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sh_ff <= 48'h0000_0000_0000;
      wr_cnt_ff <= 6'h00;
      rd_left_ff <= 6'h00;
    end
    else
    begin
      sh_ff <= nxt_sh;
      wr_cnt_ff <= enter_wr ? 6'h00 :
                   (wr_shift && wr_cnt_ff != 6'h3f) ? wr_cnt_ff + 6'h01 : wr_cnt_ff;
      rd_left_ff <= enter_rd ? rd_len : rd_shift ? rd_left_ff - 6'h01 : rd_left_ff;
    end
  end

  // ----------------------------------------
  // Commit on select fall
  // ----------------------------------------
  wire wr_end = rs_fall && mode_ff == modem_pkg::md_wr;
  wire cnt24 = wr_cnt_ff == 6'(modem_pkg::SHORT_W);
  wire cnt48 = wr_cnt_ff == 6'(modem_pkg::CREG_W);
  wire ok_norm = !ext && wr_cnt_ff >= 6'(modem_pkg::SHORT_W);
  wire ok_ext = ext && (cnt24 || cnt48);
  wire commit = wr_end && (ok_norm || ok_ext);
  wire abort_stat = wr_end && !commit && wr_cnt_ff >= 6'(modem_pkg::MIN_STAT);

  assign cif.wr_en = commit;
  assign cif.wr_full = ext && cnt48;
  assign cif.wr_data = sh_ff;

  creg_store u_store (
    .clk(clk),
    .sys_rst(sys_rst),
    .bus(cif)
  );

  // Status holds until the next write access begins
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      register_status_output <= 1'b0;
    else if (abort_stat)
      register_status_output <= 1'b1;
    else if (enter_wr)
      register_status_output <= 1'b0;
  end

  // ----------------------------------------
  // Receive line
  // ----------------------------------------
  // Idle level follows the interface select so each host sees its own idle
  wire idle_lvl = is_s;
  wire rx_bit = demod_valid ? demod_bit : idle_lvl;
  wire rx_run = mode_ff == modem_pkg::md_rx && state_ff == st_run && !mode_chg;
  // Sync data changes only at falling edges, so it is stable at rising ones
  wire nxt_rxd = in_rd ? sh_ff[47] :
                 !rx_run ? idle_lvl :
                 !sync_rx ? rx_bit :
                 !demod_valid ? idle_lvl :
                 tick_fall ? demod_bit : rxd;

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rxd <= 1'b0;
      ctrl_word <= modem_pkg::CREG_RESET;
    end
    else
    begin
      rxd <= nxt_rxd;
      ctrl_word <= creg;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  mode_decode_a: assert property (rs_s && !dir_s |=> mode_ff == modem_pkg::md_wr)
    else $error("write levels did not select write mode");
  rx_idle_a: assert property (mode_ff == modem_pkg::md_rx && !rx_run && !mode_chg
    |=> rxd == $past(is_s))
    else $error("receive line not at idle level");
  settle_hold_a: assert property (mode_chg && cur_data |=> state_ff == st_idle [*2])
    else $error("data mode ran before settle");
  tx_power_a: assert property (mode_ff == modem_pkg::md_tx && !mode_chg |=> tx_power)
    else $error("transmitter off in transmit mode");
  uart_no_clock_a: assert property (is_s && mode_ff == modem_pkg::md_tx
    && $past(mode_ff) == modem_pkg::md_tx |=> !bit_clock_line)
    else $error("bit clock ran in uart transmit");
  idle_clock_a: assert property (state_ff == st_idle |=> !bit_clock_line)
    else $error("bit clock not low while idle");
  commit_edge_a: assert property (cif.wr_en |-> rs_fall && $past(rs_s, 2))
    else $error("register written without select fall");
  short_drop_a: assert property (wr_end && !ext && wr_cnt_ff < 6'(modem_pkg::SHORT_W) |-> !cif.wr_en)
    else $error("short write was committed");
  ext_odd_a: assert property (wr_end && ext && !cnt24 && !cnt48 && wr_cnt_ff >= 6'd16
    |-> !cif.wr_en ##1 register_status_output)
    else $error("bad extended write not aborted");
  ext_low_a: assert property (cif.wr_en && !cif.wr_full
    |=> creg[47:24] == $past(creg[47:24]))
    else $error("short write touched upper bits");
  rd_first_a: assert property (enter_rd |=> ##1 rxd == $past(rd_load[47]))
    else $error("read did not start with msb");
  stat_set_a: assert property (abort_stat |=> register_status_output)
    else $error("aborted write did not raise status");
  norm_keep_a: assert property (wr_end && !ext && wr_cnt_ff >= 6'(modem_pkg::SHORT_W)
    |-> cif.wr_en && !cif.wr_full)
    else $error("long normal write not committed low");
  wr_sample_a: assert property (wr_shift |=> sh_ff[0] == $past(txd_s))
    else $error("write bit not taken at rising edge");
  sync_tx_a: assert property (tx_run && sync_tx && tick_rise
    |=> mod_bit == $past(txd_s))
    else $error("synchronous transmit bit not sampled");
  async_tx_a: assert property (tx_run && !sync_tx |=> mod_bit == $past(txd_s))
    else $error("asynchronous transmit not passed through");
  rx_async_a: assert property (mode_ff == modem_pkg::md_rx && !sync_rx && !mode_chg
    |=> !bit_clock_line)
    else $error("bit clock ran in asynchronous receive");
endmodule
`default_nettype wire

/* tb/host_model.sv */
/*
  Host model: shifts words in and out on the device bit clock.
  Assumes the port under test drives the bit clock.
*/
`timescale 1ns/10ps
`default_nettype none
module host_model (
  input wire logic bit_clock_line,
  input wire logic rxd,
  output logic txd
);
  // ----------------------------------------
  // Shifting tasks
  // ----------------------------------------
  // Level set by the host; it times its own bits when no clock runs
  initial txd = 1'b1;
  task automatic put(input logic v);
    txd = v;
  endtask
  // Bit valid over each rising edge, changed after the falling edge
  task automatic shift_in_bits(input logic [47:0] w, input int n);
    int i;
    for (i = n - 1; i >= 0; i--)
    begin
      txd = w[i];
      @(posedge bit_clock_line);
      @(negedge bit_clock_line);
      #1;
    end
    txd = ~txd; // Released line shows the inverse, not a stale bit
  endtask
  // Data taken at each rising edge, first bit is the MSB
  task automatic shift_out_bits(output logic [47:0] w, input int n);
    int i;
    w = 48'h0000_0000_0000;
    for (i = 0; i < n; i++)
    begin
      @(posedge bit_clock_line);
      w = {w[46:0], rxd};
    end
  endtask
endmodule
`default_nettype wire

/* tb/modem_host_serial_port_tb_top.sv */
/*
  Self-checking bench of the modem host serial port.
  Assumes small settle and bit times; the host model drives txd.
*/
`timescale 1ns/10ps
`default_nettype none
module modem_host_serial_port_tb_top;
  localparam int LIMIT = 40000;
  logic clk, sys_rst, reg_select, direction_line, if_select, demod_bit, demod_valid;
  logic txd, rxd, bit_clock_line, register_status_output, tx_power, mod_bit, mod_active;
  logic [47:0] ctrl_word;
  logic [47:0] rd;
  logic [7:0] pat;
  int bad_count, checked, cyc, i, len;
  typedef struct {int n; logic [47:0] d; logic [47:0] c; logic s;} row_t;
  row_t rows[10];
  // ----------------------------------------
  // Design and host
  // ----------------------------------------
  modem_host_serial_port #(.SETTLE_CYC(4), .BIT_CYC(16)) u_dut (
    .clk(clk), .sys_rst(sys_rst), .reg_select(reg_select),
    .direction_line(direction_line), .if_select(if_select), .txd(txd),
    .demod_bit(demod_bit), .demod_valid(demod_valid), .rxd(rxd),
    .bit_clock_line(bit_clock_line), .register_status_output(register_status_output),
    .tx_power(tx_power), .mod_bit(mod_bit), .mod_active(mod_active),
    .ctrl_word(ctrl_word)
  );
  host_model u_host (.bit_clock_line(bit_clock_line), .rxd(rxd), .txd(txd));
  // ----------------------------------------
  // Clock, timeout and reporting
  // ----------------------------------------
  // Free running system clock
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // A hung handshake would otherwise stall the run forever
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == LIMIT)
    begin
      bad_count = bad_count + 1;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic cmp1(input logic got, input logic exp);
    checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("mismatch at %0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  task automatic cmp48(input logic [47:0] got, input logic [47:0] exp);
    checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("mismatch at %0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  // ----------------------------------------
  // Register access
  // ----------------------------------------
  // Inputs move 1 ns after a rising edge, except the reset raised at a bit clock edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic reg_write(input logic [47:0] d, input int n);
    reg_select = 1'b1;
    direction_line = 1'b0;
    u_host.shift_in_bits(d, n);
    tick(1);
    reg_select = 1'b0; // Falling select commits or aborts
    tick(10);
  endtask
  task automatic reg_read(input int n);
    reg_select = 1'b1;
    direction_line = 1'b1;
    u_host.shift_out_bits(rd, n);
    tick(1);
    reg_select = 1'b0;
    tick(4);
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  // Rows: bit count, word shifted, expected register, expected status
  initial
  begin
    rows[0] = '{24, 48'h0000_005A_C3A5, 48'h0000_005A_C3A5, 1'b0};
    rows[1] = '{30, 48'h0000_3F12_3456, 48'h0000_0012_3456, 1'b0};
    rows[2] = '{16, 48'h0000_0000_FFFF, 48'h0000_0012_3456, 1'b1};
    rows[3] = '{15, 48'h0000_0000_7FFF, 48'h0000_0012_3456, 1'b0};
    rows[4] = '{23, 48'h0000_007F_FFFF, 48'h0000_0012_3456, 1'b1};
    rows[5] = '{24, 48'h0000_0024_BEEF, 48'h0000_0024_BEEF, 1'b0};
    rows[6] = '{48, 48'hC3C3_5A67_89AB, 48'hC3C3_5A67_89AB, 1'b0};
    rows[7] = '{30, 48'h0000_0000_0000, 48'hC3C3_5A67_89AB, 1'b1};
    rows[8] = '{24, 48'h0000_0026_1234, 48'hC3C3_5A26_1234, 1'b0};
    rows[9] = '{24, 48'h0000_0020_0000, 48'hC3C3_5A20_0000, 1'b0};
    {reg_select, direction_line, demod_bit, demod_valid} = 4'h0;
    if_select = 1'b1;
    sys_rst = 1'b1;
    tick(3);
    sys_rst = 1'b0;
    tick(2);
    cmp48(ctrl_word, 48'h0000_0000_0000);
    cmp1(bit_clock_line, 1'b0);
    for (i = 0; i < 10; i++)
    begin
      reg_write(rows[i].d, rows[i].n);
      cmp48(ctrl_word, rows[i].c);
      cmp1(register_status_output, rows[i].s);
      len = (rows[i].c[21] && rows[i].c[18]) ? 48 : 24;
      reg_read(len);
      cmp48(rd, (len == 48) ? rows[i].c : {24'h00_0000, rows[i].c[23:0]});
    end
    // Asynchronous transmit: settle, then txd straight to the modulator
    direction_line = 1'b0;
    u_host.put(1'b0);
    tick(5);
    cmp1(mod_active, 1'b0);
    tick(8);
    cmp1(mod_active, 1'b1);
    cmp1(tx_power, 1'b1);
    cmp1(mod_bit, 1'b0);
    u_host.put(1'b1);
    tick(4);
    cmp1(mod_bit, 1'b1);
    cmp1(bit_clock_line, 1'b0);
    // Asynchronous receive: idle level first, then demodulated data
    direction_line = 1'b1;
    demod_valid = 1'b1;
    tick(5);
    cmp1(rxd, 1'b1);
    tick(8);
    cmp1(rxd, 1'b0);
    demod_bit = 1'b1;
    tick(3);
    cmp1(rxd, 1'b1);
    cmp1(bit_clock_line, 1'b0);
    // SPI transmit: each bit taken at a rising bit clock edge
    if_select = 1'b0;
    direction_line = 1'b0;
    pat = 8'hB4;
    fork
      u_host.shift_in_bits({40'h00_0000_0000, pat}, 8);
      for (i = 7; i >= 0; i--)
      begin
        @(posedge bit_clock_line);
        tick(3);
        cmp1(mod_bit, pat[i]);
      end
    join
    // SPI receive without carrier: clock low, idle level of the pin
    direction_line = 1'b1;
    demod_valid = 1'b0;
    tick(14);
    cmp1(rxd, 1'b0);
    cmp1(bit_clock_line, 1'b0);
    // Bit 14 set makes the UART receive path clocked
    reg_write(48'h0000_0000_4000, 24);
    if_select = 1'b1;
    direction_line = 1'b1;
    demod_valid = 1'b1;
    u_host.shift_out_bits(rd, 4);
    cmp48(rd, 48'h0000_0000_000F);
    // Reset in mid-run while the bit clock is high: clock drops, register clears
    sys_rst = 1'b1;
    tick(1);
    cmp1(bit_clock_line, 1'b0);
    cmp48(ctrl_word, modem_pkg::CREG_RESET);
    sys_rst = 1'b0;
    tick(20);
    cmp1(rxd, 1'b1);
    cmp1(bit_clock_line, 1'b0);
    give_verdict();
  end
endmodule
`default_nettype wire
